//--- logic/jtp_cfg.svh
// jtp_cfg.svh - fixed widths, instruction codes and capture values
// for the test access port; included wherever widths or codes are used.
`ifndef JTP_CFG_SVH
`define JTP_CFG_SVH

`define JTP_IR_W      4
`define JTP_BSR_W     8
`define JTP_DR_W      32

// instruction codes
`define JTP_I_EXTEST  4'h0
`define JTP_I_INTEST  4'h1
`define JTP_I_SAMPLE  4'h2
`define JTP_I_ABORT   4'h8
`define JTP_I_ACCESS_PORT_ACCESS_INSTR   4'ha
`define JTP_I_DEBUG_PORT_ACCESS_INSTR   4'hb
`define JTP_I_IDCODE  4'he
`define JTP_I_BYPASS  4'hf

// fixed instruction-chain capture pattern and zero fills for the data and update words
`define JTP_IR_CAPT   4'h1
`define JTP_DR_ZERO   32'h0000_0000
`define JTP_BSR_ZERO  8'h00

`endif

//--- logic/jtp_pkg.sv
// jtp_pkg.sv - types shared by the test access port logic.
// assumes jtp_cfg.svh is on the include path.
`include "jtp_cfg.svh"

package jtp_pkg;

	typedef enum logic [3:0] {
		JTP_TLR    = 4'b0000,
		JTP_RTI    = 4'b0001,
		JTP_SEL_DR = 4'b0010,
		JTP_CAP_DR = 4'b0011,
		JTP_SH_DR  = 4'b0100,
		JTP_EX1_DR = 4'b0101,
		JTP_PA_DR  = 4'b0110,
		JTP_EX2_DR = 4'b0111,
		JTP_UPD_DR = 4'b1000,
		JTP_SEL_IR = 4'b1001,
		JTP_CAP_IR = 4'b1010,
		JTP_SH_IR  = 4'b1011,
		JTP_EX1_IR = 4'b1100,
		JTP_PA_IR  = 4'b1101,
		JTP_EX2_IR = 4'b1110,
		JTP_UPD_IR = 4'b1111
	} jtp_state_t;

	typedef enum logic [2:0] {
		JTP_OP_BYPASS = 3'b000,
		JTP_OP_IDCODE = 3'b001,
		JTP_OP_SAMPLE = 3'b010,
		JTP_OP_EXTEST = 3'b011,
		JTP_OP_INTEST = 3'b100,
		JTP_OP_CORE   = 3'b101
	} jtp_op_t;

	typedef struct packed {
		logic tms;
		logic tdi;
	} jtp_link_in_t;

	typedef struct packed {
		logic tdo;
		logic tdo_oe;
	} jtp_link_out_t;

	// rising-edge test clock state
	typedef struct packed {
		jtp_state_t              state;
		logic [`JTP_IR_W-1:0]    ir_sh;
		logic [`JTP_IR_W-1:0]    ir;
		logic [`JTP_DR_W-1:0]    dr_sh;
		logic [`JTP_BSR_W-1:0]   bsr_upd;
		logic                    upd_tgl;
		logic [`JTP_BSR_W-1:0]   p1;
		logic [`JTP_BSR_W-1:0]   p2;
		logic [`JTP_BSR_W-1:0]   p3;
		logic [`JTP_BSR_W-1:0]   pins;
	} jtp_tck_st_t;

	// system clock state
	typedef struct packed {
		logic [1:0]              m1;
		logic [1:0]              m2;
		logic [1:0]              m3;
		logic [1:0]              mode;
		logic                    g1;
		logic                    g2;
		logic                    g3;
		logic                    g_seen;
		logic [`JTP_BSR_W-1:0]   pins_out;
	} jtp_ref_st_t;

endpackage

//--- logic/jtp_tap.sv
// jtp_tap.sv - test access port controller with output select
// between this controller and the core debug controller.
// assumes tms/tdi change on the falling test clock edge and that the
// core debug controller sees the same tms/tdi/tck and hands back core_tdo.
//
// Functional notes
// - tms sampled each rising tck edge picks the next controller state
// - trst_n low asynchronously forces and holds test-logic-reset
// - entering test-logic-reset loads the identification instruction
// - five tck cycles with tms high reach test-logic-reset from anywhere
// - four-bit instruction chain with parallel instruction register
// - unimplemented instruction codes decode to bypass
// - serial output muxes own chain or core controller output
// - own controller decodes instruction to drive that mux select
// - controller state times capture, shift, update and picks ir or dr
// - held instruction selects which data chain is used
// - extest and intest use held data, no capture, shift or update
// - stopped tck keeps state and all register contents
// - standard plus core access-port, debug-port and abort instructions
// - tdi sampled rising edge, tdo changes on falling edge
// - tdo undriven unless shifting a chain out
`timescale 1ns/1ps
`include "jtp_cfg.svh"

module jtp_tap #(
	parameter logic [`JTP_DR_W-1:0] ID_VALUE = 32'h0000_0001 // arbitrary value
) (
	input  logic                   ref_clk,
	input  logic                   reset_n,
	input  logic                   tck,
	input  logic                   trst_n,
	input  jtp_pkg::jtp_link_in_t  link_in,
	output jtp_pkg::jtp_link_out_t link_out,
	input  logic                   core_tdo,
	output logic                   core_sel,
	input  logic [`JTP_BSR_W-1:0]  bsr_pins_in,
	output logic [`JTP_BSR_W-1:0]  bsr_pins_out,
	output logic                   extest_active,
	output logic                   intest_active
);
	import jtp_pkg::*;

	////////////////////////////////////////////////////////////////////
	// functions

	function automatic jtp_state_t jtp_next(input jtp_state_t s, input logic m);
		jtp_state_t n;
		n = JTP_TLR;
		case (s)
			JTP_TLR: begin
				if (m) begin
					n = JTP_TLR;
				end else begin
					n = JTP_RTI;
				end
			end
			JTP_RTI: begin
				if (m) begin
					n = JTP_SEL_DR;
				end else begin
					n = JTP_RTI;
				end
			end
			JTP_SEL_DR: begin
				if (m) begin
					n = JTP_SEL_IR;
				end else begin
					n = JTP_CAP_DR;
				end
			end
			JTP_CAP_DR: begin
				if (m) begin
					n = JTP_EX1_DR;
				end else begin
					n = JTP_SH_DR;
				end
			end
			JTP_SH_DR: begin
				if (m) begin
					n = JTP_EX1_DR;
				end else begin
					n = JTP_SH_DR;
				end
			end
			JTP_EX1_DR: begin
				if (m) begin
					n = JTP_UPD_DR;
				end else begin
					n = JTP_PA_DR;
				end
			end
			JTP_PA_DR: begin
				if (m) begin
					n = JTP_EX2_DR;
				end else begin
					n = JTP_PA_DR;
				end
			end
			JTP_EX2_DR: begin
				if (m) begin
					n = JTP_UPD_DR;
				end else begin
					n = JTP_SH_DR;
				end
			end
			JTP_UPD_DR: begin
				if (m) begin
					n = JTP_SEL_DR;
				end else begin
					n = JTP_RTI;
				end
			end
			JTP_SEL_IR: begin
				if (m) begin
					n = JTP_TLR;
				end else begin
					n = JTP_CAP_IR;
				end
			end
			JTP_CAP_IR: begin
				if (m) begin
					n = JTP_EX1_IR;
				end else begin
					n = JTP_SH_IR;
				end
			end
			JTP_SH_IR: begin
				if (m) begin
					n = JTP_EX1_IR;
				end else begin
					n = JTP_SH_IR;
				end
			end
			JTP_EX1_IR: begin
				if (m) begin
					n = JTP_UPD_IR;
				end else begin
					n = JTP_PA_IR;
				end
			end
			JTP_PA_IR: begin
				if (m) begin
					n = JTP_EX2_IR;
				end else begin
					n = JTP_PA_IR;
				end
			end
			JTP_EX2_IR: begin
				if (m) begin
					n = JTP_UPD_IR;
				end else begin
					n = JTP_SH_IR;
				end
			end
			JTP_UPD_IR: begin
				if (m) begin
					n = JTP_SEL_DR;
				end else begin
					n = JTP_RTI;
				end
			end
			default:    n = JTP_TLR;
		endcase
		return n;
	endfunction

	function automatic jtp_op_t jtp_decode(input logic [`JTP_IR_W-1:0] c);
		jtp_op_t o;
		o = JTP_OP_BYPASS;
		case (c)
			`JTP_I_IDCODE: o = JTP_OP_IDCODE;
			`JTP_I_SAMPLE: o = JTP_OP_SAMPLE;
			`JTP_I_EXTEST: o = JTP_OP_EXTEST;
			`JTP_I_INTEST: o = JTP_OP_INTEST;
			`JTP_I_ACCESS_PORT_ACCESS_INSTR:  o = JTP_OP_CORE;
			`JTP_I_DEBUG_PORT_ACCESS_INSTR:  o = JTP_OP_CORE;
			`JTP_I_ABORT:  o = JTP_OP_CORE;
			default:       o = JTP_OP_BYPASS;
		endcase
		return o;
	endfunction

	function automatic logic jtp_frozen(input jtp_op_t o);
		return (o == JTP_OP_EXTEST) || (o == JTP_OP_INTEST);
	endfunction

	////////////////////////////////////////////////////////////////////
	// rising tck domain

	jtp_tck_st_t t_q;
	jtp_tck_st_t t_d;
	jtp_op_t     op;

	assign op = jtp_decode(t_q.ir);

	always_comb begin
		t_d = t_q;
		t_d.state = jtp_next(t_q.state, link_in.tms);
		// pin levels come from another domain: three stages, agree to accept
		t_d.p1 = bsr_pins_in;
		t_d.p2 = t_q.p1;
		t_d.p3 = t_q.p2;
		for (int i = 0; i < `JTP_BSR_W; i++) begin
			if (t_q.p2[i] == t_q.p3[i]) begin
				t_d.pins[i] = t_q.p3[i];
			end
		end
		case (t_q.state)
			JTP_TLR: begin
				t_d.ir = `JTP_I_IDCODE;
			end
			JTP_CAP_IR: begin
				t_d.ir_sh = `JTP_IR_CAPT;
			end
			JTP_SH_IR: begin
				t_d.ir_sh = {link_in.tdi, t_q.ir_sh[`JTP_IR_W-1:1]};
			end
			JTP_UPD_IR: begin
				t_d.ir = t_q.ir_sh;
			end
			JTP_CAP_DR: begin
				case (op)
					JTP_OP_IDCODE: t_d.dr_sh = ID_VALUE;
					JTP_OP_SAMPLE: t_d.dr_sh = {{(`JTP_DR_W-`JTP_BSR_W){1'b0}},
						t_q.pins};
					JTP_OP_BYPASS: t_d.dr_sh = `JTP_DR_ZERO;
					default:       t_d.dr_sh = t_q.dr_sh;
				endcase
			end
			JTP_SH_DR: begin
				case (op)
					JTP_OP_IDCODE: t_d.dr_sh = {link_in.tdi, t_q.dr_sh[`JTP_DR_W-1:1]};
					JTP_OP_SAMPLE: t_d.dr_sh[`JTP_BSR_W-1:0] =
						{link_in.tdi, t_q.dr_sh[`JTP_BSR_W-1:1]};
					JTP_OP_BYPASS: t_d.dr_sh[0] = link_in.tdi;
					default:       t_d.dr_sh = t_q.dr_sh;
				endcase
			end
			JTP_UPD_DR: begin
				if (op == JTP_OP_SAMPLE) begin
					t_d.bsr_upd = t_q.dr_sh[`JTP_BSR_W-1:0];
					t_d.upd_tgl = ~t_q.upd_tgl;
				end
			end
			default: begin
				t_d.ir = t_q.ir;
			end
		endcase
		// a core instruction must not linger into test-logic-reset
		if (t_d.state == JTP_TLR) begin
			t_d.ir = `JTP_I_IDCODE;
		end
	end

	// no tck edge, no change: everything holds while the clock stops
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			t_q         <= '0;
			t_q.state   <= JTP_TLR;
			t_q.ir      <= `JTP_I_IDCODE;
			t_q.ir_sh   <= `JTP_IR_CAPT;
			t_q.dr_sh   <= `JTP_DR_ZERO;
			t_q.bsr_upd <= `JTP_BSR_ZERO;
		end else begin
			t_q <= t_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// falling tck domain: serial output

	jtp_link_out_t o_q;
	jtp_link_out_t o_d;
	logic          own_bit;
	logic          core_pick;

	assign core_pick = (op == JTP_OP_CORE);
	assign core_sel  = core_pick;
	assign own_bit   = (t_q.state == JTP_SH_IR) ? t_q.ir_sh[0] : t_q.dr_sh[0];

	always_comb begin
		o_d = o_q;
		o_d.tdo = (core_pick && t_q.state == JTP_SH_DR) ? core_tdo : own_bit;
		// drive only while a chain is really shifting out
		o_d.tdo_oe = (t_q.state == JTP_SH_IR) ||
			(t_q.state == JTP_SH_DR && !jtp_frozen(op));
	end

	always_ff @(negedge tck or negedge trst_n) begin
		if (!trst_n) begin
			o_q <= '0;
		end else begin
			o_q <= o_d;
		end
	end

	assign link_out = o_q;

	////////////////////////////////////////////////////////////////////
	// system clock domain

	jtp_ref_st_t r_q;
	jtp_ref_st_t r_d;
	logic [1:0]  mode_tck;

	assign mode_tck = {op == JTP_OP_INTEST, op == JTP_OP_EXTEST};

	always_comb begin
		r_d = r_q;
		r_d.m1 = mode_tck;
		r_d.m2 = r_q.m1;
		r_d.m3 = r_q.m2;
		for (int i = 0; i < 2; i++) begin
			if (r_q.m2[i] == r_q.m3[i]) begin
				r_d.mode[i] = r_q.m3[i];
			end
		end
		r_d.g1 = t_q.upd_tgl;
		r_d.g2 = r_q.g1;
		r_d.g3 = r_q.g2;
		// the update word is held in tck flops until the next update,
		// which is several tck periods away, so it is stable here
		if (r_q.g2 == r_q.g3 && r_q.g3 != r_q.g_seen) begin
			r_d.g_seen   = r_q.g3;
			r_d.pins_out = t_q.bsr_upd;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			r_q          <= '0;
			r_q.pins_out <= `JTP_BSR_ZERO;
		end else begin
			r_q <= r_d;
		end
	end

	assign bsr_pins_out  = r_q.pins_out;
	assign extest_active = r_q.mode[0];
	assign intest_active = r_q.mode[1];

endmodule

//--- bench/jtp_tester.sv
// jtp_tester.sv - behavioural boundary-scan tester on the far side of the link.
// assumes the bench calls step once per test clock and reads tdo through the pull-up.
`timescale 1ns/1ps
module jtp_tester
	import jtp_pkg::*;
(
	output logic         tck,
	output jtp_link_in_t link_in,
	input  logic         tdo_line
);
	// clock parked low between frames, stepped only inside them
	initial begin
		tck = 1'b0;
		link_in = '1;
	end
	task automatic step(input logic m, input logic d, output logic q);
		link_in.tms = m;
		link_in.tdi = d;
		#62.5 tck = 1'b1;
		q = tdo_line;
		#62.5 tck = 1'b0;
	endtask
endmodule

//--- bench/jtp_tap_chk.sv
// jtp_tap_chk.sv - port-level assertions for the test access port.
// assumes it is bound onto jtp_tap and sees only its ports.
`timescale 1ns/1ps
`include "jtp_cfg.svh"
module jtp_tap_chk
	import jtp_pkg::*;
#(
	parameter logic [`JTP_DR_W-1:0] ID_VALUE = 32'h0000_0001
) (
	input logic                   ref_clk,
	input logic                   reset_n,
	input logic                   tck,
	input logic                   trst_n,
	input jtp_pkg::jtp_link_in_t  link_in,
	input jtp_pkg::jtp_link_out_t link_out,
	input logic                   core_tdo,
	input logic                   core_sel,
	input logic [`JTP_BSR_W-1:0]  bsr_pins_in,
	input logic [`JTP_BSR_W-1:0]  bsr_pins_out,
	input logic                   extest_active,
	input logic                   intest_active
);
	logic [1:0] lo_r_q;
	// pin levels just before the rising edge; the falling edge must see them unchanged
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			lo_r_q <= 2'b00;
		end else begin
			lo_r_q <= link_out;
		end
	end
	tdo_fall_only_a: assert property (@(negedge tck) disable iff (!trst_n)
		link_out.tdo == lo_r_q[1]) else $error("tdo moved on rising tck");
	oe_fall_only_a: assert property (@(negedge tck) disable iff (!trst_n)
		link_out.tdo_oe == lo_r_q[0]) else $error("tdo enable moved on rising tck");
	trst_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!trst_n |-> !link_out.tdo_oe && !core_sel) else $error("test reset not held");
	tms_reset_a: assert property (@(posedge tck) disable iff (!trst_n)
		link_in.tms [*5] |=> !core_sel && !link_out.tdo_oe) else $error("tms reset failed");
	ir_capture_a: assert property (@(posedge tck) disable iff (!trst_n)
		link_in.tms [*5] ##1 !link_in.tms ##1 link_in.tms [*2] ##1 !link_in.tms [*2]
		|=> link_out.tdo_oe && link_out.tdo) else $error("ir capture walk wrong");
	id_first_a: assert property (@(posedge tck) disable iff (!trst_n)
		link_in.tms [*5] ##1 !link_in.tms ##1 link_in.tms ##1 !link_in.tms [*2]
		|=> link_out.tdo_oe && link_out.tdo == ID_VALUE[0]) else $error("id bit wrong");
	shift_exit_a: assert property (@(posedge tck) disable iff (!trst_n)
		link_out.tdo_oe && link_in.tms |=> !link_out.tdo_oe) else $error("tdo kept driven");
	stopped_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n || !trst_n)
		$stable(tck) |-> $stable(link_out) && $stable(core_sel)) else $error("moved while idle");
endmodule
bind jtp_tap jtp_tap_chk #(.ID_VALUE(ID_VALUE)) chk_i (.ref_clk(ref_clk), .reset_n(reset_n),
	.tck(tck), .trst_n(trst_n), .link_in(link_in), .link_out(link_out),
	.core_tdo(core_tdo), .core_sel(core_sel), .bsr_pins_in(bsr_pins_in),
	.bsr_pins_out(bsr_pins_out), .extest_active(extest_active),
	.intest_active(intest_active));

//--- bench/tb_jtp_tap.sv
// tb_jtp_tap.sv - self-checking bench for the test access port.
// assumes jtp_tester drives the link and the checker is bound in.
`timescale 1ns/1ps
module tb_jtp_tap;
	import jtp_pkg::*;
	localparam logic [31:0] ID = 32'h5a3c_96e1; // arbitrary value
	localparam logic [8:0]  M9 = 9'b011111001;
	logic          ref_clk = 1'b0;
	logic          reset_n = 1'b0;
	logic          trst_n = 1'b0;
	logic          core_tdo = 1'b0;
	logic [7:0]    pins_in = 8'h00;
	logic [7:0]    pins_out;
	logic [7:0]    d;
	logic          tck, core_sel, ext_a, int_a, b;
	logic [31:0]   q;
	logic [3:0]    codes [6] = '{4'hf, 4'h5, 4'hc, 4'h8, 4'ha, 4'hb};
	jtp_link_in_t  li;
	jtp_link_out_t lo;
	int            n_errors = 0;
	int            n_checks = 0;
	int            seed = 32'hd9bc;
	int            cyc = 0;
	// undriven pin floats up through the pull-up
	wire           tdo_w = lo.tdo_oe ? lo.tdo : 1'b1;
	always #25 ref_clk = ~ref_clk;
	jtp_tap #(.ID_VALUE(ID)) uut (.ref_clk(ref_clk), .reset_n(reset_n), .tck(tck),
		.trst_n(trst_n), .link_in(li), .link_out(lo), .core_tdo(core_tdo),
		.core_sel(core_sel), .bsr_pins_in(pins_in), .bsr_pins_out(pins_out),
		.extest_active(ext_a), .intest_active(int_a));
	jtp_tester tst (.tck(tck), .link_in(li), .tdo_line(tdo_w));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] o);
		o = '0;
		// off-phase start keeps tck edges clear of ref_clk edges
		@(posedge ref_clk) #7;
		tst.step(1'b1, 1'b0, b);
		if (ir) tst.step(1'b1, 1'b0, b);
		tst.step(1'b0, 1'b0, b);
		tst.step(1'b0, 1'b0, b);
		for (int i = 0; i < n; i++) tst.step(i == n - 1, din[i], o[i]);
		tst.step(1'b1, 1'b0, b);
		tst.step(1'b0, 1'b0, b);
	endtask
	task complete_run;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		trst_n <= 1'b1;
		// scans start from idle, so step out of test-logic-reset first
		@(posedge ref_clk) #7;
		tst.step(1'b0, 1'b0, b);
		scan(1'b0, 32, 32'h0, q);
		chk(q, ID, "idcode after reset");
		for (int k = 0; k < 6; k++) begin
			@(posedge ref_clk) core_tdo <= 1'($random(seed));
			scan(1'b1, 4, codes[k], q);
			chk(q, 32'h1, "ir capture");
			chk(core_sel, k > 2, "mux select");
			scan(1'b0, 4, 32'hf, q);
			chk(q, (k > 2) ? {4{core_tdo}} : 32'he, "dr path");
		end
		@(posedge ref_clk) pins_in <= 8'($random(seed));
		d = 8'($random(seed));
		scan(1'b1, 4, 32'h2, q);
		scan(1'b0, 8, {24'h0, d}, q);
		chk(q, pins_in, "sample capture");
		repeat (6) @(posedge ref_clk);
		chk(pins_out, d, "preload update");
		for (int k = 0; k < 2; k++) begin
			scan(1'b1, 4, k, q);
			scan(1'b0, 8, {24'h0, ~d}, q);
			repeat (6) @(posedge ref_clk);
			chk({ext_a, int_a}, k ? 2'b01 : 2'b10, "test mode");
			chk(q, 32'hff, "no shift");
			chk(pins_out, d, "no update");
		end
		for (int k = 0; k < 2; k++) begin
			// core instruction held, so the walk must also drop the output select
			scan(1'b1, 4, 32'ha, q);
			@(posedge ref_clk) #7;
			for (int i = 0; i < 9; i++) tst.step(M9[i], 1'b0, b);
			chk(core_sel, 0, "tms reset select");
			scan(k[0], k ? 4 : 32, 32'h0, q);
			chk(q, k ? 32'h1 : ID, "tms reset");
		end
		scan(1'b1, 4, 32'ha, q);
		@(posedge ref_clk) trst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk(core_sel, 0, "test reset");
		trst_n <= 1'b1;
		@(posedge ref_clk) #7;
		tst.step(1'b0, 1'b0, b);
		scan(1'b0, 32, 32'h0, q);
		chk(q, ID, "idcode after test reset");
		complete_run();
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 8000) begin
			n_errors++;
			complete_run();
		end
	end
endmodule
